// [rtl/sfd_pkg.sv]
// sfd_pkg: constants, types and decode helpers of the supply fault and
// open-load diagnostic block.
// assumes a 25 MHz core clock and a 16-bit register port with 4-bit address.
package sfd_pkg;

  // ==========================================================================
  // sizes and clock
  // ==========================================================================
  localparam int NCH = 5;
  localparam int DW = 16;
  localparam int AW = 4;
  localparam int CW = 16;
  localparam int CLK_NS = 40;

  // ==========================================================================
  // filter times in ns, and derived cycle counts (least times round up)
  // ==========================================================================
  localparam int SUPPLY_DGL_NS = 3500;
  localparam int PUMP_DGL_NS = 4000;
  localparam int OL_SHORT_NS = 64000;
  localparam int OL_LONG_NS = 2000000;
  localparam int SUPPLY_DGL_CYC = (SUPPLY_DGL_NS + CLK_NS - 1) / CLK_NS;
  localparam int PUMP_DGL_CYC = (PUMP_DGL_NS + CLK_NS - 1) / CLK_NS;
  localparam int OL_SHORT_CYC = (OL_SHORT_NS + CLK_NS - 1) / CLK_NS;
  localparam int OL_LONG_CYC = (OL_LONG_NS + CLK_NS - 1) / CLK_NS;

  // ==========================================================================
  // register indices
  // ==========================================================================
  localparam logic [AW-1:0] ADDR_QUICK = 4'h1;
  localparam logic [AW-1:0] ADDR_CH_FIRST = 4'h2;
  localparam logic [AW-1:0] ADDR_DEV = 4'h7;
  localparam logic [AW-1:0] ADDR_OUT_CTRL = 4'h8;
  localparam logic [AW-1:0] ADDR_OL_FILT = 4'h9;
  localparam logic [AW-1:0] ADDR_SMALL_LOAD = 4'hA;
  localparam logic [AW-1:0] ADDR_IRQ_ST = 4'hB;
  localparam logic [AW-1:0] ADDR_IRQ_MASK = 4'hC;

  // ==========================================================================
  // field positions and reset values
  // ==========================================================================
  localparam int BIT_DEV_FAULT = 7;
  localparam int BIT_LOAD_MISS = 6;
  localparam int BIT_PUMP_FAIL = 5;
  localparam int BIT_ON_OPEN = 0;
  localparam int BIT_SUPPLY_HIGH = 0;
  localparam int BIT_SUPPLY_LOW = 1;
  localparam int IRQ_W = 4;
  localparam int IRQ_SUPPLY_HIGH = 0;
  localparam int IRQ_SUPPLY_LOW = 1;
  localparam int IRQ_PUMP = 2;
  localparam int IRQ_OPEN = 3;
  localparam logic [NCH-1:0] RST_CH = 5'h00;
  localparam logic [IRQ_W-1:0] RST_IRQ = 4'h0;
  localparam logic [DW-1:0] RST_DATA = 16'h0000;

  // ==========================================================================
  // types
  // ==========================================================================
  typedef struct packed {
    logic wr;
    logic rd;
    logic [AW-1:0] addr;
    logic [DW-1:0] wdata;
  } sfd_bus_req_type;

  typedef enum logic [1:0] {
    PUMP_POWER_UP = 2'b00,
    PUMP_RUN = 2'b01,
    PUMP_FAULT = 2'b10
  } sfd_pump_state_type;

  // one-hot channel select for channel status register addresses
  function automatic logic [NCH-1:0] ch_sel(input logic [AW-1:0] addr);
    logic [NCH-1:0] sel;
    sel = RST_CH;
    for (int i = 0; i < NCH; i++) begin
      if (addr == ADDR_CH_FIRST + AW'(i)) begin
        sel[i] = 1'b1;
      end
    end
    return sel;
  endfunction : ch_sel

endpackage : sfd_pkg

// [rtl/sfd_deglitch.sv]
// sfd_deglitch: level filter; output follows input only after it has
// differed for limit consecutive cycles.
// assumes raw is synchronous to mclk; clr forces the level low at once.
`timescale 1ns/1ps
module sfd_deglitch #(
  parameter int CW = 16
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic raw,
  input wire logic clr,
  input wire logic [CW-1:0] limit,
  output logic level
);

  logic [CW-1:0] cnt_ff;
  logic [CW-1:0] nxt_cnt;
  logic lvl_ff;
  logic nxt_lvl;

  always_comb begin
    nxt_cnt = '0;
    nxt_lvl = lvl_ff;
    if (clr) begin
      nxt_lvl = 1'b0;
    end else if (raw != lvl_ff) begin
      if (cnt_ff >= limit - 1'b1) begin
        nxt_lvl = raw;
      end else begin
        nxt_cnt = cnt_ff + 1'b1;
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_ff <= '0;
      lvl_ff <= 1'b0;
    end else begin
      cnt_ff <= nxt_cnt;
      lvl_ff <= nxt_lvl;
    end
  end

  assign level = lvl_ff;

  AST_CLR_RESETS: assert property (@(posedge mclk) disable iff (!rst_n) clr |=> !lvl_ff)
    else $error("filter level not reset by clear");

endmodule : sfd_deglitch

// [rtl/sfd_sticky.sv]
// sfd_sticky: latched fault flag, set by its condition, cleared by a
// status read only once the condition is gone.
// assumes rd_clr is a one-cycle read strobe already decoded.
`timescale 1ns/1ps
module sfd_sticky (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic cond,
  input wire logic rd_clr,
  output logic flag
);

  logic flag_ff;
  logic nxt_flag;

  // condition still present keeps the flag through a read
  always_comb begin
    nxt_flag = cond | (flag_ff & ~rd_clr);
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      flag_ff <= 1'b0;
    end else begin
      flag_ff <= nxt_flag;
    end
  end

  assign flag = flag_ff;

  AST_READ_KEEPS: assert property (@(posedge mclk) disable iff (!rst_n) (flag_ff && !rd_clr) |=> flag_ff)
    else $error("flag dropped without a read");
  AST_READ_CLEARS: assert property (@(posedge mclk) disable iff (!rst_n) (rd_clr && !cond) |=> !flag_ff)
    else $error("flag not cleared by read after condition gone");

endmodule : sfd_sticky

// [rtl/sfd_diag.sv]
// sfd_diag: supply, charge pump and on-state open-load diagnostics for a
// five-channel high-side switch, with output gating and status registers.
// assumes all inputs synchronous to mclk; comparator inputs are high while
// their condition is present; register port gives read data a cycle later.
//
// Chosen here: the address map and strobed register access.
`timescale 1ns/1ps
// Overview of operation
// - filtered overvoltage sets supply_high_flag in device status and device_fault_summary in quick, device and channel status words
// - supply_high_flag clears only after overvoltage gone and device status read
// - load dump input forces every output off
// - under and overvoltage comparators pass a 3.5 us deglitch filter
// - no output turns on before pump first settles; commands are held meanwhile
// - pump out of range for 4.0 us disables all outputs
// - pump fault after deglitch sets pump_fail_flag and device_fault_summary
// - commands during pump fault execute, with inrush window start, on recovery
// - pump_fail_flag clears only after fault gone and quick status read
// - open-load filter of each channel runs automatically while that output is on
// - small_load_detect_select bit picks each channel's open-load threshold
// - open load sets channel quick fault, load-missing summary and channel flag
// - on_state_open_flag clears only after load returns or output goes off, and channel status read
// - open-load detection never alters the output state
// - open_filter_select picks 64 us or 2.0 ms open-load deglitch
// - open-load filter counts only with output high, resets when low
module sfd_diag #(
  parameter int OL_LONG_CYC = sfd_pkg::OL_LONG_CYC
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire sfd_pkg::sfd_bus_req_type bus_req,
  output logic [sfd_pkg::DW-1:0] rd_data,
  input wire logic vbat_ov_raw,
  input wire logic vbat_uv_raw,
  input wire logic load_dump_det,
  input wire logic pump_ok_raw,
  input wire logic [sfd_pkg::NCH-1:0] open_load_raw,
  output logic [sfd_pkg::NCH-1:0] out_en,
  output logic [sfd_pkg::NCH-1:0] inrush_current_window,
  output logic [sfd_pkg::NCH-1:0] small_load_detect_select,
  output logic irq
);

  localparam int NCH = sfd_pkg::NCH;
  localparam int DW = sfd_pkg::DW;
  localparam int CW = sfd_pkg::CW;
  localparam int IRQ_W = sfd_pkg::IRQ_W;

  // ==========================================================================
  // software registers
  // ==========================================================================
  logic [NCH-1:0] out_cmd_ff;
  logic [NCH-1:0] nxt_out_cmd;
  logic [NCH-1:0] open_filter_select_ff;
  logic [NCH-1:0] nxt_open_filter_select;
  logic [NCH-1:0] small_load_ff;
  logic [NCH-1:0] nxt_small_load;
  logic [IRQ_W-1:0] irq_mask_ff;
  logic [IRQ_W-1:0] nxt_irq_mask;
  logic wr_hit_out;
  logic wr_hit_filt;
  logic wr_hit_small;
  logic wr_hit_mask;
  logic wr_hit_irq;

  always_comb begin
    wr_hit_out = bus_req.wr && (bus_req.addr == sfd_pkg::ADDR_OUT_CTRL);
    wr_hit_filt = bus_req.wr && (bus_req.addr == sfd_pkg::ADDR_OL_FILT);
    wr_hit_small = bus_req.wr && (bus_req.addr == sfd_pkg::ADDR_SMALL_LOAD);
    wr_hit_mask = bus_req.wr && (bus_req.addr == sfd_pkg::ADDR_IRQ_MASK);
    wr_hit_irq = bus_req.wr && (bus_req.addr == sfd_pkg::ADDR_IRQ_ST);
    nxt_out_cmd = wr_hit_out ? bus_req.wdata[NCH-1:0] : out_cmd_ff;
    nxt_open_filter_select = wr_hit_filt ? bus_req.wdata[NCH-1:0] : open_filter_select_ff;
    nxt_small_load = wr_hit_small ? bus_req.wdata[NCH-1:0] : small_load_ff;
    nxt_irq_mask = wr_hit_mask ? bus_req.wdata[IRQ_W-1:0] : irq_mask_ff;
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      out_cmd_ff <= sfd_pkg::RST_CH;
      open_filter_select_ff <= sfd_pkg::RST_CH;
      small_load_ff <= sfd_pkg::RST_CH;
      irq_mask_ff <= sfd_pkg::RST_IRQ;
    end else begin
      out_cmd_ff <= nxt_out_cmd;
      open_filter_select_ff <= nxt_open_filter_select;
      small_load_ff <= nxt_small_load;
      irq_mask_ff <= nxt_irq_mask;
    end
  end

  // threshold choice goes straight to the current comparator
  assign small_load_detect_select = small_load_ff;

  // ==========================================================================
  // supply and pump filters
  // ==========================================================================
  logic ov_f;
  logic uv_f;
  logic pump_bad_f;

  sfd_deglitch #(.CW(CW)) u_ov_dgl (
    .mclk(mclk),
    .rst_n(rst_n),
    .raw(vbat_ov_raw),
    .clr(1'b0),
    .limit(CW'(sfd_pkg::SUPPLY_DGL_CYC)),
    .level(ov_f)
  );

  sfd_deglitch #(.CW(CW)) u_uv_dgl (
    .mclk(mclk),
    .rst_n(rst_n),
    .raw(vbat_uv_raw),
    .clr(1'b0),
    .limit(CW'(sfd_pkg::SUPPLY_DGL_CYC)),
    .level(uv_f)
  );

  // good pump drops the bad level at once, else recovery would fault again
  sfd_deglitch #(.CW(CW)) u_pump_dgl (
    .mclk(mclk),
    .rst_n(rst_n),
    .raw(~pump_ok_raw),
    .clr(pump_ok_raw),
    .limit(CW'(sfd_pkg::PUMP_DGL_CYC)),
    .level(pump_bad_f)
  );

  // ==========================================================================
  // pump state
  // ==========================================================================
  sfd_pkg::sfd_pump_state_type pump_st_ff;
  sfd_pkg::sfd_pump_state_type nxt_pump_st;

  // power-up waits on the raw good level; running needs the filtered bad level
  always_comb begin
    nxt_pump_st = pump_st_ff;
    case (pump_st_ff)
      sfd_pkg::PUMP_POWER_UP: begin
        if (pump_ok_raw && !pump_bad_f) begin
          nxt_pump_st = sfd_pkg::PUMP_RUN;
        end
      end
      sfd_pkg::PUMP_RUN: begin
        if (pump_bad_f) begin
          nxt_pump_st = sfd_pkg::PUMP_FAULT;
        end
      end
      sfd_pkg::PUMP_FAULT: begin
        if (pump_ok_raw) begin
          nxt_pump_st = sfd_pkg::PUMP_RUN;
        end
      end
      default: begin
        nxt_pump_st = sfd_pkg::PUMP_POWER_UP;
      end
    endcase
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      pump_st_ff <= sfd_pkg::PUMP_POWER_UP;
    end else begin
      pump_st_ff <= nxt_pump_st;
    end
  end

  // ==========================================================================
  // output gating and inrush window start
  // ==========================================================================
  logic [NCH-1:0] out_en_ff;
  logic [NCH-1:0] nxt_out_en;
  logic [NCH-1:0] inrush_ff;
  logic [NCH-1:0] nxt_inrush;
  logic outputs_allowed;

  // commands stay in out_cmd_ff, so a blocked turn-on fires once gating lifts
  always_comb begin
    outputs_allowed = (pump_st_ff == sfd_pkg::PUMP_RUN) && !uv_f && !load_dump_det;
    nxt_out_en = outputs_allowed ? out_cmd_ff : sfd_pkg::RST_CH;
    nxt_inrush = nxt_out_en & ~out_en_ff;
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      out_en_ff <= sfd_pkg::RST_CH;
      inrush_ff <= sfd_pkg::RST_CH;
    end else begin
      out_en_ff <= nxt_out_en;
      inrush_ff <= nxt_inrush;
    end
  end

  assign out_en = out_en_ff;
  assign inrush_current_window = inrush_ff;

  // ==========================================================================
  // open-load filters per channel
  // ==========================================================================
  logic [NCH-1:0] ol_f;
  logic [NCH-1:0] on_state_open_flag;
  logic [NCH-1:0] ch_rd;

  always_comb begin
    ch_rd = bus_req.rd ? sfd_pkg::ch_sel(bus_req.addr) : sfd_pkg::RST_CH;
  end

  for (genvar i = 0; i < NCH; i++) begin : g_ch
    sfd_deglitch #(.CW(CW)) u_ol_dgl (
      .mclk(mclk),
      .rst_n(rst_n),
      .raw(open_load_raw[i]),
      .clr(~out_en_ff[i]),
      .limit(open_filter_select_ff[i] ? CW'(OL_LONG_CYC) : CW'(sfd_pkg::OL_SHORT_CYC)),
      .level(ol_f[i])
    );

    sfd_sticky u_ol_flag (
      .mclk(mclk),
      .rst_n(rst_n),
      .cond(ol_f[i]),
      .rd_clr(ch_rd[i]),
      .flag(on_state_open_flag[i])
    );
  end

  // ==========================================================================
  // supply and pump flags
  // ==========================================================================
  logic supply_high_flag;
  logic supply_low_flag;
  logic pump_fail_flag;
  logic dev_rd;
  logic quick_rd;
  logic pump_fault_cond;

  always_comb begin
    dev_rd = bus_req.rd && (bus_req.addr == sfd_pkg::ADDR_DEV);
    quick_rd = bus_req.rd && (bus_req.addr == sfd_pkg::ADDR_QUICK);
    pump_fault_cond = (pump_st_ff == sfd_pkg::PUMP_FAULT);
  end

  sfd_sticky u_high_flag (
    .mclk(mclk),
    .rst_n(rst_n),
    .cond(ov_f),
    .rd_clr(dev_rd),
    .flag(supply_high_flag)
  );

  sfd_sticky u_low_flag (
    .mclk(mclk),
    .rst_n(rst_n),
    .cond(uv_f),
    .rd_clr(dev_rd),
    .flag(supply_low_flag)
  );

  sfd_sticky u_pump_flag (
    .mclk(mclk),
    .rst_n(rst_n),
    .cond(pump_fault_cond),
    .rd_clr(quick_rd),
    .flag(pump_fail_flag)
  );

  // ==========================================================================
  // status words and read port
  // ==========================================================================
  logic device_fault_summary;
  logic load_missing_summary;
  logic [NCH-1:0] channel_quick_fault;
  logic [DW-1:0] common_bits;
  logic [DW-1:0] nxt_rd_data;
  logic [DW-1:0] rd_data_ff;
  logic [IRQ_W-1:0] irq_st_ff;
  logic [IRQ_W-1:0] nxt_irq_st;
  logic [IRQ_W-1:0] irq_evt;
  logic [IRQ_W-1:0] flags_d_ff;
  logic [IRQ_W-1:0] flags_now;

  always_comb begin
    device_fault_summary = supply_high_flag | supply_low_flag | pump_fail_flag;
    load_missing_summary = |on_state_open_flag;
    channel_quick_fault = on_state_open_flag;
    common_bits = sfd_pkg::RST_DATA;
    common_bits[sfd_pkg::BIT_DEV_FAULT] = device_fault_summary;
    common_bits[sfd_pkg::BIT_LOAD_MISS] = load_missing_summary;
    nxt_rd_data = sfd_pkg::RST_DATA;
    if (bus_req.rd) begin
      case (bus_req.addr)
        sfd_pkg::ADDR_QUICK: begin
          nxt_rd_data = common_bits;
          nxt_rd_data[NCH-1:0] = channel_quick_fault;
          nxt_rd_data[sfd_pkg::BIT_PUMP_FAIL] = pump_fail_flag;
        end
        sfd_pkg::ADDR_DEV: begin
          nxt_rd_data = common_bits;
          nxt_rd_data[sfd_pkg::BIT_SUPPLY_HIGH] = supply_high_flag;
          nxt_rd_data[sfd_pkg::BIT_SUPPLY_LOW] = supply_low_flag;
        end
        sfd_pkg::ADDR_OUT_CTRL: nxt_rd_data[NCH-1:0] = out_cmd_ff;
        sfd_pkg::ADDR_OL_FILT: nxt_rd_data[NCH-1:0] = open_filter_select_ff;
        sfd_pkg::ADDR_SMALL_LOAD: nxt_rd_data[NCH-1:0] = small_load_ff;
        sfd_pkg::ADDR_IRQ_ST: nxt_rd_data[IRQ_W-1:0] = irq_st_ff;
        sfd_pkg::ADDR_IRQ_MASK: nxt_rd_data[IRQ_W-1:0] = irq_mask_ff;
        default: begin
          if (|ch_rd) begin
            nxt_rd_data = common_bits;
            nxt_rd_data[sfd_pkg::BIT_ON_OPEN] = |(ch_rd & on_state_open_flag);
          end
        end
      endcase
    end
    flags_now = {load_missing_summary, pump_fail_flag, supply_low_flag, supply_high_flag};
    irq_evt = flags_now & ~flags_d_ff;
    // a new event in the clearing cycle survives the write-one-to-clear
    nxt_irq_st = (irq_st_ff & ~(wr_hit_irq ? bus_req.wdata[IRQ_W-1:0] : sfd_pkg::RST_IRQ)) | irq_evt;
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rd_data_ff <= sfd_pkg::RST_DATA;
      irq_st_ff <= sfd_pkg::RST_IRQ;
      flags_d_ff <= sfd_pkg::RST_IRQ;
    end else begin
      rd_data_ff <= nxt_rd_data;
      irq_st_ff <= nxt_irq_st;
      flags_d_ff <= flags_now;
    end
  end

  assign rd_data = rd_data_ff;
  assign irq = |(irq_st_ff & irq_mask_ff);

  // ==========================================================================
  // checks
  // ==========================================================================
  AST_OV_FLAG: assert property (@(posedge mclk) disable iff (!rst_n) ov_f |=> supply_high_flag && device_fault_summary)
    else $error("overvoltage not flagged");
  AST_OV_LATCH: assert property (@(posedge mclk) disable iff (!rst_n)
    (supply_high_flag && ov_f) |=> supply_high_flag)
    else $error("supply high flag cleared during overvoltage");
  AST_LOAD_DUMP: assert property (@(posedge mclk) disable iff (!rst_n) load_dump_det |=> out_en_ff == 5'h00)
    else $error("output on during load dump");
  AST_OV_FILTER: assert property (@(posedge mclk) disable iff (!rst_n)
    ($rose(vbat_ov_raw) && !ov_f) |-> !ov_f [*8])
    else $error("overvoltage passed without deglitch");
  AST_PUMP_GATE: assert property (@(posedge mclk) disable iff (!rst_n)
    (pump_st_ff != sfd_pkg::PUMP_RUN) |=> out_en_ff == 5'h00)
    else $error("output on with pump unsettled");
  AST_PUMP_OFF: assert property (@(posedge mclk) disable iff (!rst_n)
    (pump_bad_f && pump_st_ff == sfd_pkg::PUMP_RUN) |=> ##1 out_en_ff == 5'h00)
    else $error("outputs not disabled on pump fault");
  AST_PUMP_FLAG: assert property (@(posedge mclk) disable iff (!rst_n)
    pump_fault_cond |=> pump_fail_flag && device_fault_summary)
    else $error("pump fault not flagged");
  AST_HELD_ON: assert property (@(posedge mclk) disable iff (!rst_n)
    (outputs_allowed && out_cmd_ff[0] && !out_en_ff[0]) |=> out_en_ff[0] && inrush_ff[0])
    else $error("held turn-on not executed");
  AST_PUMP_LATCH: assert property (@(posedge mclk) disable iff (!rst_n)
    (pump_fail_flag && !quick_rd) |=> pump_fail_flag)
    else $error("pump flag cleared without quick status read");
  AST_OL_REPORT: assert property (@(posedge mclk) disable iff (!rst_n)
    ol_f[0] |=> on_state_open_flag[0] && channel_quick_fault[0] && load_missing_summary)
    else $error("open load not reported");
  AST_OL_ONLY_ON: assert property (@(posedge mclk) disable iff (!rst_n) (!out_en_ff[0]) |=> !ol_f[0])
    else $error("open load filter active with output off");
  AST_OL_KEEP_ON: assert property (@(posedge mclk) disable iff (!rst_n)
    ($rose(ol_f[1]) && outputs_allowed && $stable(out_cmd_ff)) |-> $stable(out_en_ff))
    else $error("open load changed output");

  COV_OV: cover property (@(posedge mclk) disable iff (!rst_n) $rose(supply_high_flag));
  COV_PUMP: cover property (@(posedge mclk) disable iff (!rst_n) $fell(pump_fail_flag));
  COV_OL: cover property (@(posedge mclk) disable iff (!rst_n) $rose(on_state_open_flag[0]));
  COV_IRQ: cover property (@(posedge mclk) disable iff (!rst_n) $rose(irq));

endmodule : sfd_diag

// [sim/sfd_load_model.sv]
// sfd_load_model: load side seen by the open-load comparators of five channels.
// assumes load_gone is set by the bench; comparator only reacts while driven.
`timescale 1ns/1ps
module sfd_load_model (
  input wire logic [sfd_pkg::NCH-1:0] out_en,
  input wire logic [sfd_pkg::NCH-1:0] load_gone,
  output logic [sfd_pkg::NCH-1:0] open_load_raw
);
  // ==========================================================================
  // comparator
  // ==========================================================================
  // an unpowered channel draws no current, so the comparator stays quiet
  assign open_load_raw = out_en & load_gone;
endmodule : sfd_load_model

// [sim/supply_fault_openload_diag_tb.sv]
// supply_fault_openload_diag_tb: random and corner tests of sfd_diag.
// assumes sfd_pkg and sfd_diag compiled first; short long-filter parameter.
`timescale 1ns/1ps
module supply_fault_openload_diag_tb;
  // ==========================================================================
  // signals
  // ==========================================================================
  localparam int LONG = 40;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  sfd_pkg::sfd_bus_req_type bus_req = '0;
  logic [15:0] rd_data;
  logic vbat_ov_raw = 1'b0;
  logic vbat_uv_raw = 1'b0;
  logic load_dump_det = 1'b0;
  logic pump_ok_raw = 1'b0;
  logic [4:0] open_load_raw, out_en, inrush_current_window, small_load_detect_select;
  logic [4:0] load_gone = 5'h00;
  logic irq;
  int miscompares = 0;
  int tests_run = 0;
  int seed = 56;
  logic [15:0] v;
  logic [4:0] m;
  int t;

  always #20 mclk = ~mclk;

  sfd_diag #(.OL_LONG_CYC(LONG)) dut (.mclk(mclk), .rst_n(rst_n), .bus_req(bus_req), .rd_data(rd_data),
    .vbat_ov_raw(vbat_ov_raw), .vbat_uv_raw(vbat_uv_raw), .load_dump_det(load_dump_det),
    .pump_ok_raw(pump_ok_raw), .open_load_raw(open_load_raw), .out_en(out_en),
    .inrush_current_window(inrush_current_window), .small_load_detect_select(small_load_detect_select),
    .irq(irq));
  sfd_load_model load (.out_en(out_en), .load_gone(load_gone), .open_load_raw(open_load_raw));

  // ==========================================================================
  // tasks
  // ==========================================================================
  task automatic wrap_up;
    if (miscompares == 0 && tests_run > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : wrap_up

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask : cyc

  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge mclk);
    bus_req <= '{1'b1, 1'b0, a, d};
    @(posedge mclk);
    bus_req <= '0;
  endtask : wr

  // read data stands only in the cycle after the strobe
  task automatic rd(input logic [3:0] a, output logic [15:0] d);
    @(posedge mclk);
    bus_req <= '{1'b0, 1'b1, a, 16'h0000};
    @(posedge mclk);
    bus_req <= '0;
    #1;
    d = rd_data;
  endtask : rd

  function automatic logic [15:0] exp_quick(input logic [4:0] miss);
    return {9'h000, |miss, 1'b0, miss};
  endfunction : exp_quick

  // ==========================================================================
  // watchdog and main sequence
  // ==========================================================================
  initial begin
    repeat (20000) @(posedge mclk);
    miscompares++;
    wrap_up();
  end

  initial begin
    cyc(20);
    rst_n <= 1'b1;
    wr(4'hC, 16'h000F);
    wr(4'h8, 16'h001F);
    cyc(10);
    chk(out_en, 16'h0000);
    pump_ok_raw <= 1'b1;
    for (t = 0; t < 10 && out_en == 5'h00; t++) cyc(1);
    chk(inrush_current_window, 16'h001F);
    pump_ok_raw <= 1'b0;
    cyc(90);
    chk(out_en, 16'h001F);
    cyc(20);
    chk(out_en, 16'h0000);
    rd(4'h1, v);
    chk(v & 16'h00A0, 16'h00A0);
    pump_ok_raw <= 1'b1;
    for (t = 0; t < 10 && out_en == 5'h00; t++) cyc(1);
    chk(inrush_current_window, 16'h001F);
    rd(4'h1, v);
    chk(v & 16'h00A0, 16'h00A0);
    rd(4'h1, v);
    chk(v & 16'h00A0, 16'h0000);
    vbat_ov_raw <= 1'b1;
    cyc(50);
    vbat_ov_raw <= 1'b0;
    rd(4'h7, v);
    chk(v, 16'h0000);
    vbat_ov_raw <= 1'b1;
    cyc(120);
    rd(4'h7, v);
    chk(v, 16'h0081);
    rd(4'h7, v);
    chk(v, 16'h0081);
    chk(out_en, 16'h001F);
    vbat_ov_raw <= 1'b0;
    cyc(120);
    rd(4'h7, v);
    chk(v, 16'h0081);
    rd(4'h7, v);
    chk(v, 16'h0000);
    vbat_uv_raw <= 1'b1;
    cyc(100);
    chk(out_en, 16'h0000);
    vbat_uv_raw <= 1'b0;
    cyc(100);
    rd(4'h7, v);
    chk(v, 16'h0082);
    rd(4'h7, v);
    chk(v, 16'h0000);
    chk(out_en, 16'h001F);
    load_dump_det <= 1'b1;
    cyc(3);
    chk(out_en, 16'h0000);
    load_dump_det <= 1'b0;
    m = 5'($random(seed));
    wr(4'hA, {11'h000, m});
    cyc(2);
    chk(small_load_detect_select, {11'h000, m});
    rd(4'hF, v);
    chk(v, 16'h0000);
    wr(4'hB, 16'h000F);
    for (int f = 1; f >= 0; f--) begin
      t = f ? LONG : 1600;
      m = 5'($random(seed)) | 5'h01;
      wr(4'h8, 16'h0000);
      wr(4'h9, f ? 16'h001F : 16'h0000);
      load_gone <= m;
      wr(4'h8, 16'h001F);
      cyc(t - 10);
      wr(4'h8, 16'h0000);
      wr(4'h8, 16'h001F);
      cyc(t - 10);
      rd(4'h1, v);
      chk(v & 16'h007F, 16'h0000);
      cyc(20);
      rd(4'h1, v);
      chk(v & 16'h007F, exp_quick(m));
      chk(out_en, 16'h001F);
      chk(irq, 16'h0001);
      rd(4'hB, v);
      chk(v & 16'h0008, 16'h0008);
      wr(4'hB, 16'h000F);
      cyc(1);
      chk(irq, 16'h0000);
      load_gone <= 5'h00;
      cyc(t + 10);
      for (int i = 0; i < 5; i++) begin
        rd(4'(2 + i), v);
        chk(v & 16'h0001, {15'h0000, m[i]});
        rd(4'(2 + i), v);
        chk(v & 16'h0001, 16'h0000);
      end
    end
    wrap_up();
  end
endmodule : supply_fault_openload_diag_tb
